// >>> design/adc_fmt_pkg.sv
// Shared constants and types for the converter output formatter
package adc_fmt_pkg;
    localparam int DATA_W      = 16;
    localparam int RAW_W       = 18;
    localparam int CNT_W       = 8;
    localparam int LFSR_W      = 23;
    localparam int LFSR_TAP_HI = 22;
    localparam int LFSR_TAP_LO = 17;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h000001;

    // APB map, byte addresses
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [11:0] ADDR_OVER_COUNT = 12'h008;
    localparam int          CTRL_DITHER_BIT = 0;
    localparam logic        CTRL_RESET      = 1'b0;
    localparam int          ST_MODE_LSB     = 0;
    localparam int          ST_TWOS_BIT     = 2;
    localparam int          ST_DCS_ON_BIT   = 3;
    localparam int          ST_LOCKED_BIT   = 4;

    // Timing
    localparam int CLK_PERIOD_NS      = 100;
    localparam int STOP_TIME_NS       = 10000;
    localparam int STOP_COUNT         = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DCS_RELOCK_CYCLES  = 100;

    typedef enum logic [1:0] {
        MODE_CMOS_FULL  = 2'b00,
        MODE_CMOS_DEMUX = 2'b01,
        MODE_LVDS_LOW   = 2'b10,
        MODE_LVDS_STD   = 2'b11
    } out_mode_t;

    typedef enum logic [1:0] {
        DCS_RELOCK = 2'b00,
        DCS_LOCKED = 2'b01
    } dcs_state_t;

    typedef struct packed {
        logic              over;
        logic [DATA_W-1:0] data;
    } sample_t;
endpackage

// >>> design/dither_lfsr.sv
// Long-period pseudo-random generator for dither values
module dither_lfsr
    import adc_fmt_pkg::*;
#(
    parameter int OUT_W = DATA_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             advance,
    output logic      [OUT_W-1:0] value
);
    logic [LFSR_W-1:0] state;
    wire               feedback = state[LFSR_TAP_HI] ^ state[LFSR_TAP_LO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= LFSR_SEED;
        end else if (advance) begin
            state <= {state[LFSR_W-2:0], feedback};
        end
    end

    assign value = state[OUT_W-1:0];
endmodule // dither_lfsr

// >>> design/adc_output_formatter.sv
// Output formatter: mode decode, coding, dither removal, scrambling, output buses
// Operation
// - Output-mode pin level selects one of four modes
// - Format level sets coding and stabilizer enable
// - Flag samples outside the representable range
// - CMOS modes give one overflow flag per bus
// - LVDS modes use single overflow flag
// - Drive delayed copy of encode clock
// - Bus A changes as clock A falls
// - Demux bus B changes as clock A falls
// - Full-rate CMOS drives bus A only
// - Demux output clocks run at half rate
// - Scrambler XORs upper bits with LSB
// - LSB, flag and clock stay unscrambled
// - Scrambling only while enable input high
// - Pseudo-random generator feeds dither path
// - Subtract injected dither from each result
// - Result is 16-bit word plus flag
// - Stabilizer uses rising edge, makes fall
// - Stabilizer relocks over one hundred cycles
//
// Design decisions made here: the APB interface to the registers and the register offsets.
module adc_output_formatter
    import adc_fmt_pkg::*;
#(
    parameter int STOP_CYCLES = STOP_COUNT
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    input  wire logic              sample_clock_in,
    input  wire logic [1:0]        mode_level,
    input  wire logic [1:0]        format_level,
    input  wire logic              scramble_enable,
    input  wire logic [RAW_W-1:0]  conv_result,
    output logic      [DATA_W-1:0] dither_value,
    output logic      [DATA_W-1:0] data_a,
    output logic      [DATA_W-1:0] data_b,
    output logic                   overflow_flag,
    output logic                   overflow_flag_bus_a,
    output logic                   overflow_flag_bus_b,
    output logic                   sync_clock_a,
    output logic                   sync_clock_b,
    output logic                   sync_clock_out,
    output logic                   lvds_enable,
    output logic                   lvds_low_power,
    output logic                   bus_b_active,
    output logic                   dcs_active
);
    // Pin synchronisers: encode clock, mode level, format level, scramble enable
    logic [5:0] sync_s1;
    logic [5:0] sync_s2;
    logic       pin_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_s1  <= 6'h00;
            sync_s2  <= 6'h00;
            pin_prev <= 1'b0;
        end else begin
            sync_s1  <= {scramble_enable, format_level, mode_level, sample_clock_in};
            sync_s2  <= sync_s1;
            pin_prev <= sync_s2[0];
        end
    end

    wire       pin_rise = sync_s2[0] & ~pin_prev;
    wire       pin_fall = ~sync_s2[0] & pin_prev;
    out_mode_t mode;
    assign mode = out_mode_t'(sync_s2[2:1]);
    wire [1:0] fmt      = sync_s2[4:3];
    wire       scr_on   = sync_s2[5];
    wire       twos     = fmt[1];
    wire       dcs_on   = fmt[0] ^ fmt[1];
    wire       demux    = (mode == MODE_CMOS_DEMUX);

    assign lvds_enable    = mode[1];
    assign lvds_low_power = (mode == MODE_LVDS_LOW);
    assign bus_b_active   = demux;
    assign dcs_active     = dcs_on;

    // Duty cycle stabilizer: period measure, stop detect, relock count
    logic [CNT_W-1:0] since_rise;
    logic [CNT_W-1:0] half_period;
    logic [CNT_W-1:0] lock_cnt;
    dcs_state_t       dcs_state;

    wire [CNT_W:0] period_full = {1'b0, since_rise} + {{CNT_W{1'b0}}, 1'b1};
    wire           stopped     = (since_rise >= CNT_W'(STOP_CYCLES));
    wire           dcs_locked  = (dcs_state == DCS_LOCKED);
    wire           int_fall    = (since_rise == half_period) && (half_period != '0);
    // Before lock the external falling edge is still used so outputs keep moving
    wire           phase_fall  = (dcs_on && dcs_locked) ? int_fall : pin_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_rise  <= '0;
            half_period <= '0;
        end else if (pin_rise) begin
            since_rise  <= '0;
            half_period <= period_full[CNT_W:1];
        end else if (since_rise != '1) begin
            since_rise  <= since_rise + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcs_state <= DCS_RELOCK;
            lock_cnt  <= '0;
        end else begin
            case (dcs_state)
                DCS_RELOCK: begin
                    if (stopped) begin
                        lock_cnt <= '0;
                    end else if (pin_rise) begin
                        if (lock_cnt == CNT_W'(DCS_RELOCK_CYCLES - 1)) begin
                            dcs_state <= DCS_LOCKED;
                        end
                        lock_cnt <= lock_cnt + 1'b1;
                    end
                end
                DCS_LOCKED: begin
                    if (stopped) begin
                        dcs_state <= DCS_RELOCK;
                        lock_cnt  <= '0;
                    end
                end
                default: dcs_state <= DCS_RELOCK;
            endcase
        end
    end

    // APB slave
    logic        dither_en;
    logic [15:0] over_count;
    wire         apb_setup = psel && !penable;
    wire         apb_wr    = psel && penable && pwrite;
    wire         hit_ctrl  = (paddr == ADDR_CTRL);
    wire         hit_stat  = (paddr == ADDR_STATUS);
    wire         hit_over  = (paddr == ADDR_OVER_COUNT);
    wire         mapped    = hit_ctrl || hit_stat || hit_over;
    wire [31:0]  status_word = {27'h0, dcs_locked, dcs_on, twos, mode};
    wire [31:0]  rd_word   = hit_ctrl ? {31'h0, dither_en} :
                             hit_stat ? status_word :
                             hit_over ? {16'h0, over_count} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata    <= 32'h0;
            dither_en <= CTRL_RESET;
        end else begin
            if (apb_setup) begin
                prdata <= rd_word;
            end
            if (apb_wr && hit_ctrl) begin
                dither_en <= pwdata[CTRL_DITHER_BIT];
            end
        end
    end

    // Dither: value held on the injection path is the one removed at the next sample
    logic [DATA_W-1:0] lfsr_value;

    dither_lfsr #(
        .OUT_W   (DATA_W)
    ) u_lfsr (
        .pclk    (pclk),
        .presetn (presetn),
        .advance (pin_rise),
        .value   (lfsr_value)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dither_value <= '0;
        end else if (pin_rise || !dither_en) begin
            dither_value <= dither_en ? lfsr_value : '0;
        end
    end

    // Sample formation
    wire [RAW_W:0]    diff     = {conv_result[RAW_W-1], conv_result}
                                 - {3'b000, dither_value};
    wire              under    = diff[RAW_W];
    wire              above    = !under && (diff[RAW_W-1:DATA_W] != '0);
    wire              over_now = under || above;
    wire [DATA_W-1:0] clamped  = under ? '0 : above ? '1 : diff[DATA_W-1:0];
    wire [DATA_W-1:0] coded    = {clamped[DATA_W-1] ^ twos, clamped[DATA_W-2:0]};
    wire [DATA_W-1:0] scram    = {coded[DATA_W-1:1] ^ {(DATA_W-1){coded[0]}}, coded[0]};
    sample_t          word;
    assign word.over = over_now;
    assign word.data = scr_on ? scram : coded;

    // Over-range counter: a sample in the clearing cycle still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_count <= '0;
        end else if (pin_rise && over_now) begin
            over_count <= (apb_wr && hit_over) ? 16'h0001 : over_count + 1'b1;
        end else if (apb_wr && hit_over) begin
            over_count <= '0;
        end
    end

    // Output buses
    sample_t pend;
    logic    clk_a;
    logic    flag_a;
    logic    flag_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend   <= '0;
            clk_a  <= 1'b0;
            data_a <= '0;
            data_b <= '0;
            flag_a <= 1'b0;
            flag_b <= 1'b0;
        end else if (pin_rise && demux && clk_a) begin
            data_a <= pend.data;
            flag_a <= pend.over;
            data_b <= word.data;
            flag_b <= word.over;
            clk_a  <= 1'b0;
        end else if (pin_rise) begin
            pend  <= word;
            clk_a <= 1'b1;
            if (!demux) begin
                data_b <= '0;
                flag_b <= 1'b0;
            end
        end else if (phase_fall && !demux && clk_a) begin
            data_a <= pend.data;
            flag_a <= pend.over;
            clk_a  <= 1'b0;
        end
    end

    assign sync_clock_a        = clk_a;
    assign sync_clock_b        = ~clk_a;
    assign sync_clock_out      = clk_a;
    assign overflow_flag_bus_a = !mode[1] && flag_a;
    assign overflow_flag_bus_b = demux && flag_b;
    assign overflow_flag       = mode[1] && flag_a;

    // Checks
    sequence mode_held(logic [1:0] lvl);
        (mode_level == lvl)[*3];
    endsequence

    sequence demux_pair;
        demux && pin_rise && !clk_a ##[1:300] demux && pin_rise && clk_a;
    endsequence

    mode_full_cmos_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_held(2'b00) |-> !lvds_enable && !bus_b_active)
        else $error("ground level did not select full-rate CMOS");
    fmt_dcs_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (format_level == 2'b10)[*3] |-> dcs_active && twos)
        else $error("format level decode wrong");
    over_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_rise && ($signed(diff) < 0) && !(demux && clk_a) |=> pend.over)
        else $error("under-range sample not flagged");
    lvds_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        lvds_enable |-> !overflow_flag_bus_a && !overflow_flag_bus_b
        && (overflow_flag == flag_a))
        else $error("LVDS overflow flag routing wrong");
    bus_a_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(data_a) |-> $fell(clk_a))
        else $error("bus A changed away from clock A fall");
    bus_b_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_b_active && $changed(data_b) |-> $fell(clk_a))
        else $error("bus B changed away from clock A fall");
    demux_half_a: assert property (@(posedge pclk) disable iff (!presetn)
        demux_pair |=> !clk_a && (data_b == $past(word.data)))
        else $error("demux pairing or half-rate clock wrong");
    scramble_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_rise && scr_on && !(demux && clk_a) |=>
        ((pend.data ^ {{(DATA_W-1){pend.data[0]}}, 1'b0}) == $past(coded)))
        else $error("scrambled word does not unscramble");
    plain_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_rise && !scr_on && !(demux && clk_a) |=> pend.data == $past(coded))
        else $error("data scrambled while disabled");
    dither_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !dither_en ##1 !dither_en |-> dither_value == '0)
        else $error("dither injected while disabled");
    dither_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_rise && dither_en ##1 dither_en |-> dither_value == $past(lfsr_value))
        else $error("dither value not taken from generator");
    relock_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(dcs_locked) |-> $past(lock_cnt) == CNT_W'(DCS_RELOCK_CYCLES - 1))
        else $error("stabilizer locked after wrong count");
endmodule // adc_output_formatter

// >>> testbench/capture_model.sv
// Downstream capture logic: latches the output buses as clock A rises
module capture_model
    import adc_fmt_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              descramble,
    input  wire logic [DATA_W-1:0] data_a,
    input  wire logic [DATA_W-1:0] data_b,
    input  wire logic              sync_clock_a,
    output logic      [DATA_W-1:0] cap_a,
    output logic      [DATA_W-1:0] cap_b,
    output logic      [7:0]        period,
    output int                     odd_moves
);
    logic              ca_q = 1'b0;
    logic [7:0]        cnt  = 8'h00;
    logic [DATA_W-1:0] a_q  = '0;
    logic [DATA_W-1:0] b_q  = '0;
    initial odd_moves = 0;
    function automatic logic [DATA_W-1:0] unscr(input logic [DATA_W-1:0] w);
        return descramble ? (w ^ {{(DATA_W-1){w[0]}}, 1'b0}) : w;
    endfunction
    always @(posedge pclk) begin
        ca_q <= sync_clock_a;
        a_q  <= data_a;
        b_q  <= data_b;
        cnt  <= cnt + 8'h01;
        // Bus moves are legal only in the cycle clock A falls
        if ((data_a !== a_q || data_b !== b_q) && !(ca_q && !sync_clock_a))
            odd_moves <= odd_moves + 1;
        if (sync_clock_a && !ca_q) begin
            cap_a  <= unscr(data_a);
            cap_b  <= unscr(data_b);
            period <= cnt + 8'h01;
            cnt    <= 8'h00;
        end
    end
endmodule // capture_model

// >>> testbench/tb_adc_output_formatter.sv
// Self-checking bench for the converter output formatter
module tb_adc_output_formatter
    import adc_fmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, sample_clock_in = 0, scramble_enable = 0, run_clk = 1, alt = 0;
    logic [1:0] mode_level = '0, format_level = '0;
    logic [RAW_W-1:0] conv_result = '0, smp_x = '0, smp_y = '0;
    logic [DATA_W-1:0] dither_value, data_a, data_b, cap_a, cap_b;
    logic overflow_flag, flag_a, flag_b, sync_clock_a, sync_clock_b, sync_clock_out;
    logic lvds_enable, lvds_low_power, bus_b_active, dcs_active;
    logic [7:0] period;
    int fail_count = 0, check_count = 0, odd_moves, clk_phase = 0;
    logic [31:0] rd;
    logic err;

    adc_output_formatter #(.STOP_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sample_clock_in(sample_clock_in), .mode_level(mode_level),
        .format_level(format_level), .scramble_enable(scramble_enable),
        .conv_result(conv_result), .dither_value(dither_value), .data_a(data_a),
        .data_b(data_b), .overflow_flag(overflow_flag), .overflow_flag_bus_a(flag_a),
        .overflow_flag_bus_b(flag_b), .sync_clock_a(sync_clock_a),
        .sync_clock_b(sync_clock_b), .sync_clock_out(sync_clock_out),
        .lvds_enable(lvds_enable), .lvds_low_power(lvds_low_power),
        .bus_b_active(bus_b_active), .dcs_active(dcs_active));
    capture_model cap_u (.pclk(pclk), .descramble(scramble_enable), .data_a(data_a),
        .data_b(data_b), .sync_clock_a(sync_clock_a), .cap_a(cap_a), .cap_b(cap_b),
        .period(period), .odd_moves(odd_moves));

    initial forever #50 pclk = ~pclk;
    // Encode at 800 ns; analog core adds the injected dither to each sample
    always @(posedge pclk) begin
        if (run_clk) begin
            clk_phase <= (clk_phase + 1) % 8;
            if (clk_phase == 3) begin
                sample_clock_in <= 1'b0;
                alt             <= ~alt;
            end
            if (clk_phase == 7) sample_clock_in <= 1'b1;
        end
        conv_result <= (alt ? smp_y : smp_x) + {2'b00, dither_value};
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run(input logic [1:0] m, input logic [1:0] f, input logic s,
                       input logic [RAW_W-1:0] x, input logic [RAW_W-1:0] y, input int n);
        mode_level <= m;
        format_level <= f;
        scramble_enable <= s;
        smp_x <= x;
        smp_y <= y;
        repeat (n * 8) @(posedge pclk);
    endtask

    task automatic t_regs;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h0f, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[0], err}, 2'b01);
        $display("regs done");
    endtask
    task automatic t_full;
        int m0;
        run(2'h0, 2'h0, 1'b0, 18'h01234, 18'h01234, 6);
        m0 = odd_moves;
        chk(cap_a, 16'h1234);
        chk({data_b, flag_a}, 17'h0);
        chk(period, 8'h08);
        chk({sync_clock_out, sync_clock_b}, {sync_clock_a, ~sync_clock_a});
        run(2'h0, 2'h0, 1'b0, 18'h10005, 18'h10005, 4);
        chk({data_a, flag_a}, 17'h1ffff);
        run(2'h0, 2'h0, 1'b0, 18'h3fff0, 18'h3fff0, 4);
        chk({data_a, flag_a}, 17'h00001);
        chk(odd_moves - m0, 0);
        apb(1'b0, ADDR_OVER_COUNT, 32'h0);
        chk(rd != 0, 1);
        run(2'h0, 2'h0, 1'b0, 18'h00010, 18'h00010, 3);
        apb(1'b1, ADDR_OVER_COUNT, 32'h0);
        apb(1'b0, ADDR_OVER_COUNT, 32'h0);
        chk(rd, 32'h0);
        $display("full rate done");
    endtask
    task automatic t_coding;
        logic [15:0] w;
        for (int f = 0; f < 4; f++) begin
            for (int s = 0; s < 2; s++) begin
                run(2'h0, f[1:0], s[0], 18'h0a5c3, 18'h0a5c3, 6);
                w = (f >= 2) ? 16'h25c3 : 16'ha5c3;
                chk(cap_a, w);
                chk(data_a, s ? (w ^ {{15{w[0]}}, 1'b0}) : w);
                chk(dcs_active, f == 1 || f == 2);
                apb(1'b0, ADDR_STATUS, 32'h0);
                chk(rd & 32'h0f, {28'h0, f == 1 || f == 2, f >= 2, 2'b00});
            end
        end
        $display("coding done");
    endtask
    task automatic t_demux;
        int m0;
        run(2'h1, 2'h0, 1'b0, 18'h00111, 18'h00222, 6);
        m0 = odd_moves;
        chk(period, 8'h10);
        chk(cap_a === 16'h0111 || cap_a === 16'h0222, 1);
        chk(cap_b, cap_a === 16'h0111 ? 16'h0222 : 16'h0111);
        chk(bus_b_active, 1'b1);
        run(2'h1, 2'h0, 1'b0, 18'h00111, 18'h20000, 4);
        chk(flag_b, data_b === 16'h0000);
        chk(flag_a ^ flag_b, 1'b1);
        chk(odd_moves - m0, 0);
        $display("demux done");
    endtask
    task automatic t_lvds;
        for (int m = 2; m < 4; m++) begin
            run(m[1:0], 2'h0, 1'b0, 18'h3ffff, 18'h3ffff, 5);
            chk({overflow_flag, lvds_enable, lvds_low_power}, {2'b11, m == 2});
            chk(data_a, 16'h0000);
        end
        $display("lvds done");
    endtask
    task automatic t_dither;
        logic [15:0] d0;
        apb(1'b1, ADDR_CTRL, 32'h1);
        run(2'h0, 2'h0, 1'b0, 18'h04321, 18'h04321, 8);
        d0 = dither_value;
        chk(cap_a, 16'h4321);
        repeat (8) @(posedge pclk);
        chk(dither_value != d0, 1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        run(2'h0, 2'h0, 1'b0, 18'h04321, 18'h04321, 4);
        chk({dither_value, cap_a}, {16'h0, 16'h4321});
        $display("dither done");
    endtask
    task automatic t_stab;
        run(2'h0, 2'h1, 1'b0, 18'h00777, 18'h00777, 110);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4:3], 2'b11);
        chk(cap_a, 16'h0777);
        run_clk <= 1'b0;
        repeat (40) @(posedge pclk);
        run_clk <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4], 1'b0);
        $display("stabilizer done");
    endtask

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_full();
        t_coding();
        t_demux();
        t_lvds();
        t_dither();
        t_stab();
        close_out();
    end
    // Whole run needs about 1800 cycles; allow more than five times that
    initial begin
        #1000000;
        fail_count++;
        close_out();
    end
endmodule // tb_adc_output_formatter
